// >>> hdl/ielf_pkg.sv
// Constants and types for the interrupt entry and flush block
package ielf_pkg;
  localparam int SLOTS  = 4;
  localparam int KIND_W = 4;
  localparam int AOFF_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_IRQ_SAVED = 8'h08;
  localparam logic [7:0] OFF_IRQ_LINK  = 8'h0C;
  localparam logic [7:0] OFF_FIQ_SAVED = 8'h10;
  localparam logic [7:0] OFF_FIQ_LINK  = 8'h14;
  localparam logic [7:0] OFF_VBASE     = 8'h18;
  localparam logic [7:0] OFF_STATE     = 8'h1C;

  // Register bit fields, mode codes, reset values and vector offsets
  localparam int CTRL_LL_BIT = 0;
  localparam int SW_MODE_LSB = 0;
  localparam int SW_MODE_MSB = 4;
  localparam int SW_F_BIT    = 6;
  localparam int SW_I_BIT    = 7;
  localparam int STATE_NMFI_BIT = 1;
  localparam logic [4:0]  MODE_FIQ = 5'h11;
  localparam logic [4:0]  MODE_IRQ = 5'h12;
  localparam logic [31:0] STATUS_RST = 32'h0000_00D3;
  localparam logic [31:0] VBASE_RST  = 32'h0000_0000;
  localparam logic [31:0] VEC_IRQ    = 32'h0000_0018;
  localparam logic [31:0] VEC_FIQ    = 32'h0000_001C;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h1;

  // Classes of in-flight instruction seen by the flush picker
  typedef enum logic [3:0] {
    KIND_ALU        = 4'b0000,
    KIND_LS_WAIT    = 4'b0001,
    KIND_LS_NORMAL  = 4'b0010,
    KIND_FP_DIV     = 4'b0011,
    KIND_FP_SQRT    = 4'b0100,
    KIND_CACHE_OP   = 4'b0101,
    KIND_BARRIER    = 4'b0110,
    KIND_LS_DEVICE  = 4'b0111,
    KIND_LSM_DEVICE = 4'b1000,
    KIND_PERIPH     = 4'b1001,
    KIND_FIXED      = 4'b1010
  } ielf_kind_t;

  typedef enum logic [0:0] {
    ST_RUN   = 1'b0,
    ST_DRAIN = 1'b1
  } ielf_state_t;
endpackage : ielf_pkg

// >>> hdl/ielf_flush_pick.sv
// Picks in-flight slots to flush on low-latency interrupt entry
`timescale 1ns/1ns
`default_nettype none
module ielf_flush_pick
  import ielf_pkg::*;
#(
  parameter bit ADVANCED = 1'b0
)
(
  input  wire logic [SLOTS-1:0]        slot_valid,
  input  wire logic [SLOTS*KIND_W-1:0] slot_kind,
  input  wire logic [SLOTS-1:0]        slot_in_lsu,
  input  wire logic                    ll_en,
  output logic      [SLOTS-1:0]        flush
);

  function automatic logic restartable(input logic [KIND_W-1:0] k,
                                       input logic in_lsu);
    logic r;
    r = 1'b0;
    unique case (k)
      KIND_ALU,
      KIND_LS_WAIT:    r = 1'b1;
      KIND_LS_NORMAL:  r = 1'b1;
      KIND_FP_DIV,
      KIND_FP_SQRT,
      KIND_CACHE_OP,
      KIND_BARRIER:    r = 1'b1;
      // Simple variant drops these only behind a flushed slot; advanced also before LSU
      KIND_LS_DEVICE:  r = ADVANCED && !in_lsu;
      KIND_LSM_DEVICE: r = 1'b0;
      KIND_PERIPH:     r = 1'b0;
      default:         r = 1'b0;
    endcase
    return r;
  endfunction : restartable

  // Slot 0 is oldest; a flushed slot drags each younger valid slot along up to the first empty one
  always_comb
  begin
    logic carry;
    carry = 1'b0;
    for (int i = 0; i < SLOTS; i++)
    begin
      carry = ll_en && slot_valid[i] &&
              (carry || restartable(slot_kind[i*KIND_W +: KIND_W],
                                    slot_in_lsu[i]));
      flush[i] = carry;
    end
  end

endmodule : ielf_flush_pick
`default_nettype wire

// >>> hdl/ielf_irq_entry.sv
// IRQ/FAST_INTERRUPT_REQUEST entry, return and low-latency flush control with AHB-Lite regs
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - On IRQ entry the interrupted PC goes into the IRQ link register.
// - On IRQ entry the status word is copied to IRQ saved status.
// - On IRQ entry status mode becomes IRQ and the IRQ mask sets.
// - On IRQ entry the PC jumps to the IRQ vector entry.
// - IRQ or FAST_INTERRUPT_REQUEST is taken only while its mask bit is clear.
// - Strap at reset stops software masking FAST_INTERRUPT_REQUEST; FAST_INTERRUPT_REQUEST entry still masks it.
// - Return restores PC and status together in one step.
// - Without low-latency mode all in-flight instructions complete.
// - Low-latency mode flushes restartable work and unstarted accesses.
// - Low-latency mode also replays started normal-memory accesses.
// - Low-latency mode flushes FP divide/sqrt, cache ops, barriers.
// - Younger instructions behind a flushed one are flushed up to the first empty slot.
// - Simple variant flushes device or ordered accesses only behind an older flushed one.
// - Advanced variant also flushes single device accesses still before the LSU.
// - Issued multi-register device accesses complete before entry unless behind a flushed one.
// - Started peripheral-port accesses complete unless behind a flushed one.
module ielf_irq_entry
  import ielf_pkg::*;
#(
  parameter bit ADVANCED = 1'b0
)
(
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    ce,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic                    irq_req_n,
  input  wire logic                    fast_interrupt_request_n,
  input  wire logic                    nmfi_cfg,
  input  wire logic [31:0]             resume_pc,
  input  wire logic [SLOTS-1:0]        slot_valid,
  input  wire logic [SLOTS*KIND_W-1:0] slot_kind,
  input  wire logic [SLOTS-1:0]        slot_in_lsu,
  input  wire logic                    rfe_valid,
  input  wire logic [31:0]             rfe_pc,
  input  wire logic [31:0]             rfe_status,
  output logic                         issue_hold,
  output logic      [SLOTS-1:0]        flush_mask,
  output logic                         redirect_valid,
  output logic      [31:0]             redirect_pc,
  output logic      [31:0]             current_status_word
);

  logic [AOFF_W-1:0] ap_addr_reg;
  logic              ap_valid_reg;
  logic              ap_write_reg;
  logic              ctrl_ll_reg;
  logic [31:0]       vbase_reg;
  logic [31:0]       status_reg;
  logic [31:0]       irq_saved_reg;
  logic [31:0]       irq_link_reg;
  logic [31:0]       fiq_saved_reg;
  logic [31:0]       fiq_link_reg;
  logic              nmfi_reg;
  logic              strap_done_reg;
  logic              kind_fiq_reg;
  ielf_state_t       state_reg;
  logic [31:0]       rd_data;
  logic [SLOTS-1:0]  flush_pick;

  // Bus decode
  wire bus_take  = hsel && hready && htrans[1] && ce;
  wire dp_do     = ap_valid_reg && ce;
  wire wr_ctrl   = dp_do && ap_write_reg && ap_addr_reg == OFF_CTRL;
  wire wr_status = dp_do && ap_write_reg && ap_addr_reg == OFF_STATUS;
  wire wr_vbase  = dp_do && ap_write_reg && ap_addr_reg == OFF_VBASE;

  // Interrupt recognition; requests are active low
  wire fiq_pend  = !fast_interrupt_request_n && !status_reg[SW_F_BIT];
  wire irq_pend  = !irq_req_n && !status_reg[SW_I_BIT];
  wire in_run    = state_reg == ST_RUN;
  wire rfe_go    = ce && in_run && rfe_valid;
  wire recog_go  = ce && in_run && !rfe_valid &&
                   (fiq_pend || irq_pend);
  wire drained   = slot_valid == '0;
  wire entry_go  = ce && state_reg == ST_DRAIN && drained;

  function automatic logic [31:0] entry_word(input logic [31:0] sw,
                                             input logic fast_interrupt_request);
    logic [31:0] w;
    w = sw;
    w[SW_MODE_MSB:SW_MODE_LSB] = fast_interrupt_request ? MODE_FIQ : MODE_IRQ;
    w[SW_I_BIT] = 1'b1;
    if (fast_interrupt_request)
      w[SW_F_BIT] = 1'b1;
    return w;
  endfunction : entry_word

  // Software may clear F under the strap but never set it
  wire sw_f_new = nmfi_reg ? (status_reg[SW_F_BIT] && hwdata[SW_F_BIT])
                           : hwdata[SW_F_BIT];
  wire [31:0] sw_write_word = {hwdata[31:SW_F_BIT+1], sw_f_new,
                               hwdata[SW_F_BIT-1:0]};
  wire [31:0] entry_status  = entry_word(status_reg, kind_fiq_reg);
  wire [31:0] entry_vector  = vbase_reg + (kind_fiq_reg ? VEC_FIQ : VEC_IRQ);

  assign rd_data =
    ap_addr_reg == OFF_CTRL      ? {31'h0000_0000, ctrl_ll_reg} :
    ap_addr_reg == OFF_STATUS    ? status_reg    :
    ap_addr_reg == OFF_IRQ_SAVED ? irq_saved_reg :
    ap_addr_reg == OFF_IRQ_LINK  ? irq_link_reg  :
    ap_addr_reg == OFF_FIQ_SAVED ? fiq_saved_reg :
    ap_addr_reg == OFF_FIQ_LINK  ? fiq_link_reg  :
    ap_addr_reg == OFF_VBASE     ? vbase_reg     :
    ap_addr_reg == OFF_STATE     ? {30'h0000_0000, nmfi_reg, state_reg} :
    32'h0000_0000;

  ielf_flush_pick #(.ADVANCED(ADVANCED)) u_pick (
    .slot_valid  (slot_valid),
    .slot_kind   (slot_kind),
    .slot_in_lsu (slot_in_lsu),
    .ll_en       (ctrl_ll_reg),
    .flush       (flush_pick)
  );

  // One wait state so read data leaves from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg  <= '0;
      hreadyout    <= 1'b1;
      hrdata       <= 32'h0000_0000;
      hresp        <= 1'b0;
    end
    else if (bus_take)
    begin
      ap_valid_reg <= 1'b1;
      ap_write_reg <= hwrite;
      ap_addr_reg  <= {haddr[AOFF_W-1:2], 2'b00};
      hreadyout    <= 1'b0;
    end
    else if (dp_do)
    begin
      ap_valid_reg <= 1'b0;
      hrdata       <= ap_write_reg ? 32'h0000_0000 : rd_data;
      hreadyout    <= 1'b1;
    end
  end

  // Static configuration registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ll_reg <= 1'b0;
      vbase_reg   <= VBASE_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ll_reg <= hwdata[CTRL_LL_BIT];
      if (wr_vbase)
        vbase_reg <= hwdata;
    end
  end

  // Strap is caught on the first enabled edge after reset release
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nmfi_reg       <= 1'b0;
      strap_done_reg <= 1'b0;
    end
    else if (ce && !strap_done_reg)
    begin
      nmfi_reg       <= nmfi_cfg;
      strap_done_reg <= 1'b1;
    end
  end

  // Status word: hardware events override a software write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_reg <= STATUS_RST;
    else if (rfe_go)
      status_reg <= rfe_status;
    else if (entry_go)
      status_reg <= entry_status;
    else if (wr_status)
      status_reg <= sw_write_word;
  end

  // Banked link and saved status capture at entry
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_saved_reg <= 32'h0000_0000;
      irq_link_reg  <= 32'h0000_0000;
      fiq_saved_reg <= 32'h0000_0000;
      fiq_link_reg  <= 32'h0000_0000;
    end
    else if (entry_go && kind_fiq_reg)
    begin
      fiq_saved_reg <= status_reg;
      fiq_link_reg  <= resume_pc;
    end
    else if (entry_go)
    begin
      irq_saved_reg <= status_reg;
      irq_link_reg  <= resume_pc;
    end
  end

  // Recognise, flush, drain, then vector
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg      <= ST_RUN;
      kind_fiq_reg   <= 1'b0;
      issue_hold     <= 1'b0;
      flush_mask     <= '0;
      redirect_valid <= 1'b0;
      redirect_pc    <= 32'h0000_0000;
    end
    else if (ce)
    begin
      flush_mask     <= '0;
      redirect_valid <= 1'b0;
      if (rfe_go)
      begin
        redirect_valid <= 1'b1;
        redirect_pc    <= rfe_pc;
      end
      else if (recog_go)
      begin
        state_reg    <= ST_DRAIN;
        kind_fiq_reg <= fiq_pend;
        issue_hold   <= 1'b1;
        flush_mask   <= flush_pick;
      end
      else if (entry_go)
      begin
        state_reg      <= ST_RUN;
        issue_hold     <= 1'b0;
        redirect_valid <= 1'b1;
        redirect_pc    <= entry_vector;
      end
    end
  end

  assign current_status_word = status_reg;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_LINK_SAVE:
    assert property (entry_go && !kind_fiq_reg |=>
                     irq_link_reg == $past(resume_pc))
      else $error("IRQ link not loaded from resume pc");
  AST_SAVED_STATUS:
    assert property (entry_go && !kind_fiq_reg |=>
                     irq_saved_reg == $past(status_reg))
      else $error("IRQ saved status not old status");
  AST_MODE_MASK:
    assert property (entry_go && !kind_fiq_reg |=>
                     status_reg[SW_MODE_MSB:SW_MODE_LSB] == MODE_IRQ &&
                     status_reg[SW_I_BIT])
      else $error("IRQ entry did not set mode and mask");
  AST_VECTOR:
    assert property (entry_go && !kind_fiq_reg |=>
                     redirect_valid &&
                     redirect_pc == $past(vbase_reg) + VEC_IRQ)
      else $error("IRQ entry vector wrong");
  AST_MASKED_HOLD:
    assert property (in_run && !rfe_valid && status_reg[SW_I_BIT] &&
                     status_reg[SW_F_BIT] |=> state_reg == ST_RUN)
      else $error("Interrupt taken while masked");
  AST_NMFI_SET:
    assert property (nmfi_reg && $rose(status_reg[SW_F_BIT]) |->
                     $past(entry_go) || $past(rfe_go))
      else $error("Software masked FAST_INTERRUPT_REQUEST under strap");
  AST_RETURN:
    assert property (rfe_go |=> redirect_valid &&
                     redirect_pc == $past(rfe_pc) &&
                     status_reg == $past(rfe_status))
      else $error("Return did not restore pc and status");
  AST_DRAIN_FIRST:
    assert property (redirect_valid && !$past(rfe_go) |->
                     $past(slot_valid) == '0 && !issue_hold)
      else $error("Vectored before pipeline drained");
  AST_LL_OFF:
    assert property (recog_go && !ctrl_ll_reg |=> flush_mask == '0 &&
                     issue_hold)
      else $error("Flush issued with low latency off");
  AST_YOUNGER:
    assert property (flush_mask[0] && $past(slot_valid[1]) |->
                     flush_mask[1])
      else $error("Younger slot not flushed");
  AST_DEVICE_KEPT:
    assert property (recog_go && !ADVANCED &&
                     slot_kind[KIND_W-1:0] == KIND_LS_DEVICE |=>
                     !flush_mask[0])
      else $error("Device access flushed on simple variant");

endmodule : ielf_irq_entry
`default_nettype wire

// >>> verif/ielf_intc_model.sv
// Behavioural interrupt controller driving the two request lines
`timescale 1ns/1ns
`default_nettype none
module ielf_intc_model
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic irq_raise,
  input  wire logic fiq_raise,
  output logic      irq_req_n,
  output logic      fast_interrupt_request_n
);
  // Level held low for as long as the source is pending, never pulsed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_req_n                <= 1'b1;
      fast_interrupt_request_n <= 1'b1;
    end
    else
    begin
      irq_req_n                <= !irq_raise;
      fast_interrupt_request_n <= !fiq_raise;
    end
  end
endmodule : ielf_intc_model
`default_nettype wire

// >>> verif/test_irq_entry_low_latency_flush.sv
// Self-checking bench for the interrupt entry and flush block
`timescale 1ns/1ns
`default_nettype none
module test_irq_entry_low_latency_flush
  import ielf_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, irq_raise, fiq_raise, rfe_valid;
  logic        nmfi;
  logic [31:0] haddr, hwdata, resume_pc, rfe_pc, rfe_status, rd, hrdata;
  logic [31:0] redirect_pc, current_status_word;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  slot_valid, flush_mask;
  logic [15:0] slot_kind;
  logic        hreadyout, hresp, irq_req_n, fiq_n, issue_hold, redirect_valid;
  int          mismatches, total_checks, i, n;
  // Row: low-latency enable, slot kinds (slot0 oldest, low nibble), flush
  logic [20:0] rows [7] = '{
    {1'b0, KIND_ALU, KIND_ALU, KIND_ALU, KIND_ALU, 4'b0000},
    {1'b1, KIND_ALU, KIND_ALU, KIND_ALU, KIND_ALU, 4'b1111},
    {1'b1, KIND_ALU, KIND_ALU, KIND_LS_WAIT, KIND_LS_DEVICE, 4'b1110},
    // Peripheral port access has a kind of its own, flushed only behind a flushed slot
    {1'b1, KIND_ALU, KIND_ALU, KIND_LS_NORMAL, KIND_PERIPH, 4'b1110},
    // Only one multi-register device access in flight
    {1'b1, KIND_ALU, KIND_FP_SQRT, KIND_FP_DIV, KIND_LSM_DEVICE, 4'b1110},
    {1'b1, KIND_ALU, KIND_BARRIER, KIND_CACHE_OP, KIND_LS_DEVICE, 4'b1110},
    {1'b1, KIND_ALU, KIND_LS_DEVICE, KIND_LS_DEVICE, KIND_LS_DEVICE,
     4'b1000}};
  logic [39:0] regs [5] = '{{OFF_STATUS, STATUS_RST}, {OFF_CTRL, 32'h0},
    {OFF_VBASE, VBASE_RST}, {OFF_STATE, 32'h0}, {8'h20, 32'h0}};

  ielf_intc_model intc
  (
    .hclk                     (hclk),
    .hresetn                  (hresetn),
    .irq_raise                (irq_raise),
    .fiq_raise                (fiq_raise),
    .irq_req_n                (irq_req_n),
    .fast_interrupt_request_n (fiq_n)
  );

  ielf_irq_entry uut
  (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq_req_n(irq_req_n), .fast_interrupt_request_n(fiq_n),
    .nmfi_cfg(nmfi), .resume_pc(resume_pc), .slot_valid(slot_valid),
    .slot_kind(slot_kind), .slot_in_lsu(4'h0), .rfe_valid(rfe_valid),
    .rfe_pc(rfe_pc), .rfe_status(rfe_status), .issue_hold(issue_hold),
    .flush_mask(flush_mask), .redirect_valid(redirect_valid),
    .redirect_pc(redirect_pc), .current_status_word(current_status_word)
  );

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Single word transfer; waits on the slave, never on a fixed count
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr  <= {24'h0000_00, a};
    hwrite <= w;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", hresp, 32'h0);
  endtask : ahb

  task results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  task irq_row(input logic [20:0] r);
    @(posedge hclk);
    slot_kind  <= r[19:4];
    slot_valid <= 4'hf;
    resume_pc  <= {11'h000, r};
    irq_raise  <= 1'b1;
    for (n = 0; n < 20 && issue_hold !== 1'b1; n++) @(posedge hclk) #1;
    chk("flush_mask", flush_mask, r[3:0]);
    @(posedge hclk);
    slot_valid <= ~r[3:0];
    @(posedge hclk);
    slot_valid <= 4'h0;
    for (n = 0; n < 20 && redirect_valid !== 1'b1; n++) @(posedge hclk) #1;
    chk("irq_pc", redirect_pc, VBASE_RST + VEC_IRQ);
    chk("irq_status", current_status_word, 32'h0000_00D2);
    repeat (4) @(posedge hclk);
    chk("masked_retake", issue_hold, 32'h0);
    irq_raise <= 1'b0;
    ahb(1'b0, OFF_IRQ_SAVED, 32'h0);
    chk("irq_saved", rd, 32'h0000_0050);
    ahb(1'b0, OFF_IRQ_LINK, 32'h0);
    chk("irq_link", rd, {11'h000, r});
    @(posedge hclk);
    rfe_valid  <= 1'b1;
    rfe_pc     <= 32'h0000_2000;
    rfe_status <= 32'h0000_0050;
    @(posedge hclk);
    rfe_valid  <= 1'b0;
    #1;
    chk("rfe_pulse", redirect_valid, 32'h1);
    chk("rfe_pc", redirect_pc, 32'h0000_2000);
    chk("rfe_status", current_status_word, 32'h0000_0050);
  endtask : irq_row

  initial
  begin
    #100000;
    mismatches++;
    $display("watchdog expired");
    results();
  end

  initial
  begin
    {hsel, hwrite, irq_raise, fiq_raise, rfe_valid} = 5'h10;
    {haddr, hwdata, resume_pc, rfe_pc, rfe_status} = '0;
    {htrans, hsize, slot_valid, slot_kind} = '0;
    nmfi = 1'b0;
    mismatches = 0;
    total_checks = 0;
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // Unmapped write must leave the unmapped read at zero
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
    foreach (regs[i])
    begin
      ahb(1'b0, regs[i][39:32], 32'h0);
      chk("reg_reset", rd, regs[i][31:0]);
    end
    $display("test registers done");
    // Restored status with I clear lets each later row be taken
    ahb(1'b1, OFF_STATUS, 32'h0000_0050);
    foreach (rows[i])
    begin
      ahb(1'b1, OFF_CTRL, 32'(rows[i][20]));
      irq_row(rows[i]);
      $display("test row %0d done", i);
    end
    ahb(1'b1, OFF_VBASE, 32'h0000_0100);
    ahb(1'b1, OFF_STATUS, 32'h0000_0010);
    @(posedge hclk);
    irq_raise <= 1'b1;
    fiq_raise <= 1'b1;
    for (n = 0; n < 20 && redirect_valid !== 1'b1; n++) @(posedge hclk) #1;
    chk("fiq_pc", redirect_pc, 32'h0000_0100 + VEC_FIQ);
    chk("fiq_mode", {current_status_word[SW_F_BIT], current_status_word[4:0]},
        {1'b1, MODE_FIQ});
    @(posedge hclk);
    irq_raise <= 1'b0;
    fiq_raise <= 1'b0;
    ahb(1'b0, OFF_FIQ_SAVED, 32'h0);
    chk("fiq_saved", rd, 32'h0000_0010);
    $display("test fiq done");
    // Second reset with the strap on: software may clear F, never set it
    nmfi    <= 1'b1;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b1, OFF_STATUS, 32'h0000_0010);
    ahb(1'b1, OFF_STATUS, 32'h0000_0050);
    ahb(1'b0, OFF_STATE, 32'h0);
    chk("nmfi_state", rd, 32'h0000_0002);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk("nmfi_f", rd, 32'h0000_0010);
    $display("test strap done");
    results();
  end
endmodule : test_irq_entry_low_latency_flush
`default_nettype wire
